// ==== shared/pus_pkg.sv ====
// Shared constants, carrier types and timing for the power-up sequencer.
package pus_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
   localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
   localparam int unsigned PUMP_WAKE_MS   = 10;
   localparam int unsigned STAGGER_MS     = 10;
   localparam int unsigned RELEASE_MS     = 300;
   localparam int unsigned OCP_MASK_MS    = 1;
   localparam int unsigned CLEAR_FILT_NS  = 2500;
   localparam int unsigned BLANK_LONG_NS  = 5000;
   localparam int unsigned BLANK_SHORT_NS = 2500;

   // Least times round up to whole cycles, never below one cycle.
   function automatic int unsigned ns_up(input int unsigned ns);
      int unsigned c;
      c = (ns * CYC_PER_US + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned PUMP_WAKE_CYC   = PUMP_WAKE_MS * CYC_PER_MS;
   localparam int unsigned STAGGER_CYC     = STAGGER_MS * CYC_PER_MS;
   localparam int unsigned RELEASE_CYC     = RELEASE_MS * CYC_PER_MS;
   localparam int unsigned OCP_MASK_CYC    = OCP_MASK_MS * CYC_PER_MS;
   localparam int unsigned CLEAR_FILT_CYC  = ns_up(CLEAR_FILT_NS);
   localparam int unsigned BLANK_LONG_CYC  = ns_up(BLANK_LONG_NS);
   localparam int unsigned BLANK_SHORT_CYC = ns_up(BLANK_SHORT_NS);
   localparam int unsigned CNT_W           = 24;
   localparam int unsigned CHOP_OSC_CLOCKS = 8;
   localparam int unsigned CHOP_CNT_W      = 3;

   // ------------------------------------------------------------------
   // Setup bank 0 layout
   // ------------------------------------------------------------------
   localparam int unsigned    SETUP_W       = 12;
   localparam logic [11:0]    SETUP_RST     = 12'h080;
   localparam int unsigned    SETUP_A_OFF   = 7;
   localparam int unsigned    SETUP_B_OFF   = 8;
   localparam int unsigned    SETUP_C_OFF   = 9;
   localparam int unsigned    SETUP_LDO_ON  = 10;
   localparam int unsigned    BLANK_FIELD_W = 2;
   localparam logic [1:0]     BLANK_SHORT   = 2'h1;
   localparam int unsigned    BRIDGES       = 3;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_GND  = 2'b00,
      SEL_MID  = 2'b01,
      SEL_OPEN = 2'b10
   } pus_sel_t;

   typedef enum logic [1:0] {
      SQ_IDLE    = 2'b00,
      SQ_PUMP    = 2'b01,
      SQ_STAGGER = 2'b10,
      SQ_DONE    = 2'b11
   } pus_seq_t;

   typedef struct packed {
      logic ldo;
      logic c;
      logic b;
      logic a;
   } pus_regs_t;

   typedef struct packed {
      logic       supplyRiseThreshold;
      logic       chanADisable;
      logic       sleepCtrl_n;
      logic       serialStrobe;
      logic       motorChopOsc;
      logic       ldoOcp;
      logic [2:0] phase;
      logic [2:0] currentTrip;
      logic [1:0] supplySelectPin;
   } pus_pins_t;

   localparam int unsigned PINS_W = $bits(pus_pins_t);

endpackage

// ==== rtl/pus_deglitch.sv ====
// Three-stage input synchroniser with a stable-time filter.
module pus_deglitch
   import pus_pkg::*;
#(
   parameter int unsigned   W    = 1,
   parameter int unsigned   FILT = 1,
   parameter logic [W-1:0]  RST  = '0
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   // Data
   input  wire logic [W-1:0]  din,
   output logic      [W-1:0]  dout
);

   if (FILT < 1 || FILT > 65535) begin : g_bad_filt
      $error("pus_deglitch: FILT out of range");
   end

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
      logic [15:0]  cnt;
   } pus_dg_st_t;

   localparam pus_dg_st_t ST_RST = '{s1: RST, s2: RST, s3: RST, q: RST, cnt: 16'h0000};

   pus_dg_st_t st_ff;
   pus_dg_st_t nxt_st;

   // A change counts only once the second and third stages agree, and only
   // after it has stood for FILT cycles, so shorter pulses never pass.
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = din;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      if (st_ff.s2 == st_ff.s3 && st_ff.s3 != st_ff.q) begin
         if (st_ff.cnt >= 16'(FILT - 1)) begin
            nxt_st.q   = st_ff.s3;
            nxt_st.cnt = 16'h0000;
         end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
         end
      end else begin
         nxt_st.cnt = 16'h0000;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dout = st_ff.q;

endmodule

// ==== rtl/pus_blank_timer.sv ====
// Blanking interval timer and current-trip qualifier for one H-bridge.
module pus_blank_timer
   import pus_pkg::*;
#(
   parameter int unsigned LONG_CYC  = BLANK_LONG_CYC,
   parameter int unsigned SHORT_CYC = BLANK_SHORT_CYC
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Bridge control
   input  wire logic        run,
   input  wire logic        phase,
   input  wire logic        chopTick,
   input  wire logic [1:0]  blankSel,
   // Trip detection
   input  wire logic        currentTrip,
   output logic             blanking,
   output logic             tripQualified
);

   if (LONG_CYC < 1 || LONG_CYC > 65535 || SHORT_CYC < 1 || SHORT_CYC > 65535) begin : g_bad
      $error("pus_blank_timer: blanking length out of range");
   end

   typedef struct packed {
      logic        phasePrev;
      logic [15:0] cnt;
      logic        tripOk;
   } pus_bt_st_t;

   pus_bt_st_t st_ff;
   pus_bt_st_t nxt_st;

   always_comb begin
      nxt_st           = st_ff;
      nxt_st.phasePrev = phase;
      if (phase != st_ff.phasePrev || chopTick) begin
         nxt_st.cnt = (blankSel == BLANK_SHORT) ? 16'(SHORT_CYC) : 16'(LONG_CYC);
      end else if (st_ff.cnt != 16'h0000) begin
         nxt_st.cnt = st_ff.cnt - 16'h0001;
      end
      // Trips during the blanking window come from capacitive inrush, not load.
      nxt_st.tripOk = run & currentTrip & (st_ff.cnt == 16'h0000);
      if (!run) begin
         nxt_st.cnt = 16'h0000;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign blanking      = (st_ff.cnt != 16'h0000);
   assign tripQualified = st_ff.tripOk;

endmodule

// ==== rtl/pus_power_up_sequencer.sv ====
// Start-up sequencer: supply-select capture, pump, converters and reset out.
// Function
// - Open enables B and C, mid B, ground none.
// - Capture select when supply rises past threshold.
// - Pin governs until setup written, then bits 8-10.
// - Open case: B first, C after stagger delay.
// - A on only if bit7 low, disable pin low.
// - Setup bit 7 resets to one.
// - System clear stops everything, restores register defaults.
// - Clear release resamples select, reruns start-up.
// - Deglitch system clear; short low pulses ignored.
// - Pump starts first; converters wait wake delay.
// - LDO follows B at start, setup afterwards.
// - Grounded select: reset output released after 300ms.
// - Mask LDO overcurrent after each regulator start.
// - Strobed enable starts at once if pump runs.
// - Blank trips at phase reversal and chop cycle.
// - Setup bit pairs choose each bridge's blanking length.
module pus_power_up_sequencer
   import pus_pkg::*;
#(
   parameter int unsigned PUMP_CYC  = PUMP_WAKE_CYC,
   parameter int unsigned STAG_CYC  = STAGGER_CYC,
   parameter int unsigned REL_CYC   = RELEASE_CYC,
   parameter int unsigned MASK_CYC  = OCP_MASK_CYC,
   parameter int unsigned FILT_CYC  = CLEAR_FILT_CYC
) (
   // Clock and power-on reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // Pins from the host and the analog front end
   input  wire logic                systemClear_n,
   input  wire pus_pins_t           pins,
   // Setup bank 0 word from the serial shifter, applied at the strobe
   input  wire logic [SETUP_W-1:0]  setupData,
   // Regulator and pump control
   output pus_regs_t                buckEnable,
   output logic                     pumpEnable,
   output logic                     powerGoodOut_n,
   // Status
   output pus_sel_t                 supplySelectCode,
   output logic [SETUP_W-1:0]       setupValue,
   output logic                     ldoOcpMasked,
   output logic                     ldoOcpTrip,
   // H-bridges
   output logic                     bridgeRun,
   output logic [BRIDGES-1:0]       blanking,
   output logic [BRIDGES-1:0]       tripQualified
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   localparam int unsigned CNT_MAX = (1 << CNT_W) - 1;

   if (PUMP_CYC < 1 || PUMP_CYC > CNT_MAX) begin : g_bad_pump
      $error("pus_power_up_sequencer: PUMP_CYC out of range");
   end
   if (STAG_CYC < 1 || STAG_CYC > CNT_MAX) begin : g_bad_stag
      $error("pus_power_up_sequencer: STAG_CYC out of range");
   end
   if (REL_CYC < 1 || REL_CYC > CNT_MAX) begin : g_bad_rel
      $error("pus_power_up_sequencer: REL_CYC out of range");
   end
   if (MASK_CYC < 1 || MASK_CYC > CNT_MAX) begin : g_bad_mask
      $error("pus_power_up_sequencer: MASK_CYC out of range");
   end

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   logic       clearOk;
   pus_pins_t  pin;
   logic [PINS_W-1:0] pinBits;

   // The clear pin idles released, so its filter starts released too.
   pus_deglitch #(
      .W    (1),
      .FILT (FILT_CYC),
      .RST  (1'b1)
   ) u_clear_filt (
      .clock (clock),
      .rst_n (rst_n),
      .din   (systemClear_n),
      .dout  (clearOk)
   );

   pus_deglitch #(
      .W    (PINS_W),
      .FILT (1),
      .RST  ('0)
   ) u_pin_sync (
      .clock (clock),
      .rst_n (rst_n),
      .din   (pins),
      .dout  (pinBits)
   );

   assign pin = pus_pins_t'(pinBits);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      pus_seq_t            seq;
      pus_sel_t            sel;
      logic                written;
      logic [SETUP_W-1:0]  setup;
      logic [CNT_W-1:0]    pumpCnt;
      logic [CNT_W-1:0]    stagCnt;
      logic [CNT_W-1:0]    relCnt;
      logic [CNT_W-1:0]    maskCnt;
      logic                pumpOn;
      logic                pumpReady;
      logic                bootB;
      logic                bootC;
      logic                bootLdo;
      logic                powerGood;
      pus_regs_t           regs;
      logic [CHOP_CNT_W-1:0] chopCnt;
      logic                chopTick;
      logic                oscPrev;
      logic                strobePrev;
      logic                ocpTrip;
   } pus_top_st_t;

   localparam pus_top_st_t ST_DEFAULT = '{
      seq:        SQ_IDLE,
      sel:        SEL_GND,
      written:    1'b0,
      setup:      SETUP_RST,
      pumpCnt:    '0,
      stagCnt:    '0,
      relCnt:     '0,
      maskCnt:    '0,
      pumpOn:     1'b0,
      pumpReady:  1'b0,
      bootB:      1'b0,
      bootC:      1'b0,
      bootLdo:    1'b0,
      powerGood:  1'b0,
      regs:       '0,
      chopCnt:    '0,
      chopTick:   1'b0,
      oscPrev:    1'b0,
      strobePrev: 1'b0,
      ocpTrip:    1'b0
   };

   pus_top_st_t st_ff;
   pus_top_st_t nxt_st;

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      pus_regs_t target;
      pus_sel_t  capSel;
      target = '0;
      capSel = SEL_GND;
      nxt_st = st_ff;
      nxt_st.chopTick   = 1'b0;
      nxt_st.oscPrev    = pin.motorChopOsc;
      nxt_st.strobePrev = pin.serialStrobe;

      // One chopping cycle is eight rising edges of the motor oscillator.
      if (pin.motorChopOsc && !st_ff.oscPrev) begin
         if (st_ff.chopCnt == CHOP_CNT_W'(CHOP_OSC_CLOCKS - 1)) begin
            nxt_st.chopCnt  = '0;
            nxt_st.chopTick = 1'b1;
         end else begin
            nxt_st.chopCnt = st_ff.chopCnt + 1'b1;
         end
      end

      // Strobes are accepted at any time except while clear is held; spurious data during ramp-up is
      // kept out by the host holding off strobes until release.
      if (pin.serialStrobe && !st_ff.strobePrev) begin
         nxt_st.setup   = setupData;
         nxt_st.written = 1'b1;
      end

      case (st_ff.seq)
         SQ_IDLE: begin
            if (pin.supplyRiseThreshold) begin
               // The unused code 2'b11 is taken as ground: no regulator starts.
               case (pin.supplySelectPin)
                  SEL_MID:  capSel = SEL_MID;
                  SEL_OPEN: capSel = SEL_OPEN;
                  default:  capSel = SEL_GND;
               endcase
               nxt_st.sel    = capSel;
               nxt_st.relCnt = '0;
               nxt_st.seq    = SQ_PUMP;
            end
         end
         SQ_PUMP: begin
            if (st_ff.pumpReady) begin
               if (st_ff.sel != SEL_GND) begin
                  nxt_st.bootB   = 1'b1;
                  nxt_st.bootLdo = 1'b1;
               end
               nxt_st.stagCnt = '0;
               nxt_st.seq = (st_ff.sel == SEL_OPEN) ? SQ_STAGGER : SQ_DONE;
            end
         end
         SQ_STAGGER: begin
            if (st_ff.stagCnt == CNT_W'(STAG_CYC - 1)) begin
               nxt_st.bootC = 1'b1;
               nxt_st.seq   = SQ_DONE;
            end else begin
               nxt_st.stagCnt = st_ff.stagCnt + 1'b1;
            end
         end
         SQ_DONE: begin
            nxt_st.seq = SQ_DONE;
         end
         default: begin
            nxt_st.seq = SQ_IDLE;
         end
      endcase

      // Reset output release is timed from the capture, whatever the select.
      if (st_ff.seq != SQ_IDLE && !st_ff.powerGood) begin
         if (st_ff.relCnt == CNT_W'(REL_CYC - 1)) begin
            nxt_st.powerGood = 1'b1;
         end else begin
            nxt_st.relCnt = st_ff.relCnt + 1'b1;
         end
      end

      // Boot values govern until the first setup write, then setup bits do.
      target.a = ~st_ff.setup[SETUP_A_OFF] & ~pin.chanADisable;
      if (st_ff.written) begin
         target.b   = ~st_ff.setup[SETUP_B_OFF];
         target.c   = ~st_ff.setup[SETUP_C_OFF];
         target.ldo = st_ff.setup[SETUP_LDO_ON];
      end else begin
         target.b   = st_ff.bootB;
         target.c   = st_ff.bootC;
         target.ldo = st_ff.bootLdo;
      end

      // The pump never runs before capture; afterwards it runs while any
      // regulator is wanted or the device is awake.
      nxt_st.pumpOn = (st_ff.seq != SQ_IDLE)
                      & ((st_ff.seq == SQ_PUMP) | target.a | target.b | target.c
                         | target.ldo | pin.sleepCtrl_n);
      if (!st_ff.pumpOn) begin
         nxt_st.pumpCnt   = '0;
         nxt_st.pumpReady = 1'b0;
      end else if (!st_ff.pumpReady) begin
         if (st_ff.pumpCnt == CNT_W'(PUMP_CYC - 1)) begin
            nxt_st.pumpReady = 1'b1;
         end else begin
            nxt_st.pumpCnt = st_ff.pumpCnt + 1'b1;
         end
      end

      // A running pump lets a strobed enable take effect at once.
      nxt_st.regs = target & {4{st_ff.pumpReady}};

      // Every regulator start reopens the overcurrent mask window.
      if ((nxt_st.regs & ~st_ff.regs) != 4'h0) begin
         nxt_st.maskCnt = CNT_W'(MASK_CYC);
      end else if (st_ff.maskCnt != '0) begin
         nxt_st.maskCnt = st_ff.maskCnt - 1'b1;
      end
      nxt_st.ocpTrip = pin.ldoOcp & st_ff.regs.ldo & (st_ff.maskCnt == '0);

      // A held clear keeps everything at its defaults; its release sends
      // the sequence back through capture from idle.
      if (!clearOk) begin
         nxt_st = ST_DEFAULT;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_DEFAULT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------------
   // H-bridge blanking
   // ------------------------------------------------------------------
   for (genvar i = 0; i < BRIDGES; i++) begin : g_bridge
      pus_blank_timer #(
         .LONG_CYC  (BLANK_LONG_CYC),
         .SHORT_CYC (BLANK_SHORT_CYC)
      ) u_blank (
         .clock         (clock),
         .rst_n         (rst_n),
         .run           (st_ff.powerGood),
         .phase         (pin.phase[i]),
         .chopTick      (st_ff.chopTick),
         .blankSel      (st_ff.setup[BLANK_FIELD_W*i +: BLANK_FIELD_W]),
         .currentTrip   (pin.currentTrip[i]),
         .blanking      (blanking[i]),
         .tripQualified (tripQualified[i])
      );
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign buckEnable       = st_ff.regs;
   assign pumpEnable       = st_ff.pumpOn;
   assign powerGoodOut_n   = st_ff.powerGood;
   assign supplySelectCode = st_ff.sel;
   assign setupValue       = st_ff.setup;
   assign ldoOcpMasked     = (st_ff.maskCnt != '0);
   assign ldoOcpTrip       = st_ff.ocpTrip;
   assign bridgeRun        = st_ff.powerGood;

endmodule

// ==== testbench/pus_host_model.sv ====
// Host controller model driving clear, sleep and the serial setup strobe.
module pus_host_model
   import pus_pkg::*;
(
   // Clock and device status
   input  wire logic          clock,
   input  wire logic          powerGoodOut_n,
   // Host lines
   output logic               systemClear_n,
   output logic               sleepCtrl_n,
   output logic               serialStrobe,
   output logic [SETUP_W-1:0] setupData
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      systemClear_n = 1'b1;
      sleepCtrl_n   = 1'b1;
      serialStrobe  = 1'b0;
      setupData     = 12'h000;
   end

   // A strobe edge before release could latch junk, so writes wait for it.
   task automatic write_setup(input logic [SETUP_W-1:0] d);
      while (powerGoodOut_n !== 1'b1) @(posedge clock);
      @(posedge clock);
      setupData <= d;
      @(posedge clock);
      serialStrobe <= 1'b1;
      repeat (3) @(posedge clock);
      serialStrobe <= 1'b0;
      repeat (3) @(posedge clock);
      setupData <= ~d;
   endtask

   task automatic set_sleep(input logic v);
      @(posedge clock);
      sleepCtrl_n <= v;
   endtask

   task automatic drive_clear(input logic v);
      @(posedge clock);
      systemClear_n <= v;
   endtask
endmodule

// ==== testbench/pus_power_up_sequencer_monitor.sv ====
// Concurrent checks on the power-up sequencer ports.
module pus_power_up_sequencer_monitor
   import pus_pkg::*;
#(
   parameter int unsigned STAG_CYC = STAGGER_CYC,
   parameter int unsigned REL_CYC  = RELEASE_CYC
) (
   input wire logic               clock,
   input wire logic               rst_n,
   input wire logic               systemClear_n,
   input wire pus_pins_t          pins,
   input wire pus_regs_t          buckEnable,
   input wire logic               pumpEnable,
   input wire logic               powerGoodOut_n,
   input wire pus_sel_t           supplySelectCode,
   input wire logic [SETUP_W-1:0] setupValue,
   input wire logic               ldoOcpMasked,
   input wire logic               ldoOcpTrip,
   input wire logic [BRIDGES-1:0] blanking
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int STG    = STAG_CYC - 2;
   localparam int REL_LO = REL_CYC - 4;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_boot_a;
      !$past(rst_n) |-> setupValue == SETUP_RST && !buckEnable.a;
   endproperty
   a_boot_a: assert property (p_boot_a) else $error("boot a");
   property p_a_gate;
      buckEnable.a |-> !$past(setupValue[SETUP_A_OFF]);
   endproperty
   a_a_gate: assert property (p_a_gate) else $error("a gate");
   property p_pump_first;
      ($rose(buckEnable.b) || $rose(buckEnable.c)) |-> $past(pumpEnable, 8);
   endproperty
   a_pump_first: assert property (p_pump_first) else $error("pump");
   property p_stagger;
      $rose(buckEnable.b) && supplySelectCode == SEL_OPEN && !powerGoodOut_n
         |-> (!buckEnable.c throughout ##STG 1) ##[1:3] buckEnable.c;
   endproperty
   a_stagger: assert property (p_stagger) else $error("stagger");
   property p_ldo_boot;
      !powerGoodOut_n |-> buckEnable.ldo == buckEnable.b;
   endproperty
   a_ldo_boot: assert property (p_ldo_boot) else $error("ldo");
   property p_release;
      $rose(pumpEnable) |-> (!powerGoodOut_n throughout ##REL_LO 1) ##[1:6] powerGoodOut_n;
   endproperty
   a_release: assert property (p_release) else $error("release");
   property p_clear;
      (!systemClear_n)[*8] ##1 (!systemClear_n)[*6] |-> buckEnable == 4'h0
         && !pumpEnable && !powerGoodOut_n && setupValue == SETUP_RST;
   endproperty
   a_clear: assert property (p_clear) else $error("clear");
   property p_glitch;
      pumpEnable ##1 !systemClear_n ##1 systemClear_n[*8] |-> pumpEnable;
   endproperty
   a_glitch: assert property (p_glitch) else $error("glitch");
   property p_ocp;
      $rose(buckEnable.ldo) |-> ##1 ldoOcpMasked[*8];
   endproperty
   a_ocp: assert property (p_ocp) else $error("ocp mask");
   property p_blank_start;
      $changed(pins.phase[0]) && powerGoodOut_n |-> ##[2:6] blanking[0];
   endproperty
   a_blank_start: assert property (p_blank_start) else $error("blank");
   property p_blank_short;
      $rose(blanking[0]) && setupValue[1:0] == BLANK_SHORT
         |-> (blanking[0] throughout ##96 1) ##[1:6] !blanking[0];
   endproperty
   a_blank_short: assert property (p_blank_short) else $error("short");
   property p_blank_long;
      $rose(blanking[1]) && setupValue[3:2] == 2'h0
         |-> (blanking[1] throughout ##196 1) ##[1:6] !blanking[1];
   endproperty
   a_blank_long: assert property (p_blank_long) else $error("long");
endmodule

bind pus_power_up_sequencer pus_power_up_sequencer_monitor #(
   .STAG_CYC(STAG_CYC), .REL_CYC(REL_CYC)) mon (
   .clock(clock), .rst_n(rst_n), .systemClear_n(systemClear_n), .pins(pins),
   .buckEnable(buckEnable), .pumpEnable(pumpEnable), .powerGoodOut_n(powerGoodOut_n),
   .supplySelectCode(supplySelectCode), .setupValue(setupValue),
   .ldoOcpMasked(ldoOcpMasked), .ldoOcpTrip(ldoOcpTrip), .blanking(blanking));

// ==== testbench/tb_pus_power_up_sequencer.sv ====
// Self-checking bench for the power-up sequencer.
module tb_pus_power_up_sequencer
   import pus_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PUMP = 20;
   localparam int STAG = 20;
   localparam int REL  = 200;

   logic clock;
   logic rst_n = 1'b0;
   pus_pins_t pinDrv = '0;
   pus_pins_t pins;
   logic clearN, sleepN, strobe;
   logic [SETUP_W-1:0] setupData, setupValue;
   pus_regs_t buckEnable;
   logic pumpEnable, powerGoodOut_n, ldoOcpMasked, ldoOcpTrip, bridgeRun;
   pus_sel_t supplySelectCode;
   logic [BRIDGES-1:0] blanking, tripQualified;
   int miscompares = 0;
   int samples_checked = 0;
   pus_sel_t selTab [3] = '{SEL_GND, SEL_MID, SEL_OPEN};

   always_comb begin
      pins = pinDrv;
      pins.sleepCtrl_n = sleepN;
      pins.serialStrobe = strobe;
   end

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   pus_host_model host (.clock(clock), .powerGoodOut_n(powerGoodOut_n),
      .systemClear_n(clearN), .sleepCtrl_n(sleepN), .serialStrobe(strobe),
      .setupData(setupData));

   pus_power_up_sequencer #(.PUMP_CYC(PUMP), .STAG_CYC(STAG), .REL_CYC(REL),
      .MASK_CYC(10), .FILT_CYC(4)) dut (
      .clock(clock), .rst_n(rst_n), .systemClear_n(clearN), .pins(pins),
      .setupData(setupData), .buckEnable(buckEnable), .pumpEnable(pumpEnable),
      .powerGoodOut_n(powerGoodOut_n), .supplySelectCode(supplySelectCode),
      .setupValue(setupValue), .ldoOcpMasked(ldoOcpMasked), .ldoOcpTrip(ldoOcpTrip),
      .bridgeRun(bridgeRun), .blanking(blanking), .tripQualified(tripQualified));

   task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Waits a bounded time for the pump after a capture.
   task automatic wait_pump();
      int n = 0;
      while (pumpEnable !== 1'b1 && n < 60) begin
         cyc(1);
         n++;
      end
      chk("pump", pumpEnable, 12'h1);
      chk("b early", buckEnable.b, 12'h0);
   endtask

   initial begin
      cyc(20000);
      miscompares++;
      $display("Error watchdog expected done seen timeout");
      stop_test();
   end

   initial begin
      foreach (selTab[i]) begin
         rst_n <= 1'b0;
         pinDrv.supplyRiseThreshold <= 1'b0;
         pinDrv.supplySelectPin <= selTab[i];
         cyc(5);
         rst_n <= 1'b1;
         cyc(3);
         pinDrv.supplyRiseThreshold <= 1'b1;
         wait_pump();
         chk("code", supplySelectCode, selTab[i]);
         chk("setup", setupValue, SETUP_RST);
         cyc(PUMP + 6);
         chk("b", buckEnable.b, selTab[i] != SEL_GND);
         chk("ldo", buckEnable.ldo, selTab[i] != SEL_GND);
         chk("c mid", buckEnable.c, 12'h0);
         chk("a", buckEnable.a, 12'h0);
         cyc(STAG + 4);
         chk("c", buckEnable.c, selTab[i] == SEL_OPEN);
         cyc(REL - 60);
         chk("pg early", powerGoodOut_n, 12'h0);
         cyc(14);
         chk("pg", powerGoodOut_n, 12'h1);
         host.set_sleep(1'b0);
         cyc(8);
         chk("pump slp", pumpEnable, selTab[i] != SEL_GND);
         host.set_sleep(1'b1);
      end
      host.write_setup(12'h201);
      cyc(6);
      chk("setup w", setupValue, 12'h201);
      chk("a on", buckEnable.a, 12'h1);
      chk("c off", buckEnable.c, 12'h0);
      chk("ldo off", buckEnable.ldo, 12'h0);
      pinDrv.chanADisable <= 1'b1;
      pinDrv.currentTrip <= 3'h7;
      pinDrv.phase <= 3'h7;
      cyc(10);
      chk("a pin", buckEnable.a, 12'h0);
      chk("blank", blanking[0], 12'h1);
      chk("trip", tripQualified, 12'h0);
      cyc(110);
      chk("trip short", tripQualified, 12'h1);
      cyc(100);
      chk("trip long", tripQualified, 12'h7);
      repeat (7) begin
         pinDrv.motorChopOsc <= 1'b1;
         cyc(2);
         pinDrv.motorChopOsc <= 1'b0;
         cyc(2);
      end
      chk("chop 7", blanking, 12'h0);
      pinDrv.motorChopOsc <= 1'b1;
      cyc(8);
      chk("chop 8", blanking, 12'h7);
      cyc(100);
      chk("bl short", blanking, 12'h6);
      cyc(100);
      chk("bl long", blanking, 12'h0);
      pinDrv.currentTrip <= 3'h0;
      pinDrv.ldoOcp <= 1'b1;
      host.write_setup(12'h400);
      cyc(3);
      chk("c fast", buckEnable.c, 12'h1);
      chk("mask", ldoOcpMasked, 12'h1);
      chk("ocp hid", ldoOcpTrip, 12'h0);
      cyc(20);
      chk("ocp", ldoOcpTrip, 12'h1);
      pinDrv.ldoOcp <= 1'b0;
      host.drive_clear(1'b0);
      host.drive_clear(1'b1);
      cyc(12);
      chk("glitch", {pumpEnable, buckEnable}, 12'h1E);
      pinDrv.supplySelectPin <= SEL_MID;
      host.drive_clear(1'b0);
      cyc(16);
      chk("clr en", {pumpEnable, buckEnable}, 12'h0);
      chk("clr set", setupValue, SETUP_RST);
      chk("clr pg", powerGoodOut_n, 12'h0);
      host.drive_clear(1'b1);
      wait_pump();
      chk("recap", supplySelectCode, SEL_MID);
      cyc(PUMP + STAG + 10);
      chk("reboot", buckEnable, 12'hA);
      stop_test();
   end
endmodule
